//--- tb/mmvd_decoder_bench.sv
`default_nettype none
module mmvd_decoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import mmvd_pkg::*;
   logic clk, rst_n, sv, bt, ld, km, s_rs, s_lp, s_cg;
   mmvd_req_t req;
   mmvd_sel_out_t so;
   logic [7:0] z, sr, fr, rd, prot, opt, acc;
   logic [15:0] fa, a;
   logic [63:0] key, kc, ka, kb;
   int fails = 0;
   int tests_run = 0;
   int seed = 66;
   localparam logic [15:0] vt [14] = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8, 16'hfff6,
      16'hfff0, 16'hffe6, 16'hffe2, 16'hffe0, 16'hffde, 16'hffda, 16'hffd8, 16'hffd6, 16'hffce};
   localparam logic [15:0] cn [16] = '{16'h0000, 16'h005f, 16'h0060, 16'h025f, 16'h0260,
      16'h17ff, 16'h1800, 16'h184f, 16'h1850, 16'hdfff, 16'he000, 16'hffaf, 16'hffb0,
      16'hffbf, 16'hffc0, 16'hffcd};
   localparam logic [15:0] hp [7] = '{16'h1800, 16'h1809, 16'h180e, 16'h180f, 16'h1801,
      16'h1808, 16'h184f};
   localparam logic [2:0] hs [7] = '{3'h4, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0};
   mmvd_decoder i_mmvd_decoder (.clk(clk), .rst_n(rst_n), .req(req), .unused_zero_mask(z),
      .slot_rdata(sr), .flash_rdata(fr), .sel_out(so), .sel_valid(sv), .rdata(rd),
      .bit_test(bt), .flash_addr(fa), .loading(ld), .nv_protection_byte(prot),
      .nv_option_byte(opt), .backdoor_key(key), .key_match(km), .key_candidate(kc),
      .hp_reset_status_sel(s_rs), .hp_low_power_sel(s_lp), .hp_clk_gate_sel(s_cg));
   mmvd_mem_model i_mmvd_mem_model (.clk(clk), .sel_out(so), .flash_addr(fa),
      .slot_rdata(sr), .flash_rdata(fr));
   // ==========
   // expectations
   function automatic logic [7:0] fp(input logic [15:0] x);
      return x[7:0] ^ x[15:8] ^ 8'h5a;
   endfunction
   function automatic mmvd_sel_t es(input logic [15:0] x);
      if (x <= 16'h005f) return MMVD_SEL_DP;
      if (x <= 16'h025f) return MMVD_SEL_RAM;
      if (x >= 16'h1800 && x <= 16'h184f) return MMVD_SEL_HP;
      return x >= 16'he000 ? MMVD_SEL_FLASH : MMVD_SEL_NONE;
   endfunction
   task automatic check(input logic [63:0] s, input logic [63:0] e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("ERROR %0t seen %0h expected %0h", $time, s, e);
      end
   endtask
   task automatic go(input logic w, d, f, input logic [3:0] src, input logic [15:0] x,
      input logic [7:0] wd, bm, zm, input logic [1:0] op);
      @(posedge clk);
      req <= '{1'b1, w, d, f, mmvd_src_t'(src), x[0], x, wd, bm, op};
      z <= zm;
      @(negedge clk);
   endtask
   task automatic idle;
      @(posedge clk);
      req.valid <= 1'b0;
      @(negedge clk);
   endtask
   // refused request held through reset and load
   task automatic rst(input int n);
      @(posedge clk);
      rst_n <= 1'b0;
      req <= '{1'b1, 1'b0, 1'b0, 1'b0, MMVD_SRC_RESET, 1'b0, 16'h0010, 8'h00, 8'h00, 2'h0};
      repeat (n) @(posedge clk);
      @(negedge clk);
      check({ld, prot, so.sel, sv}, {1'b1, 8'hff, MMVD_SEL_NONE, 1'b0});
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({ld, prot, opt}, {1'b0, fp(16'hffbd), fp(16'hffbf)});
      idle;
      repeat (12) @(posedge clk);
      $display("test reset done");
   endtask
   task automatic results;
      $display("tests_run %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #20000;
      fails++;
      $display("ERROR %0t watchdog expired", $time);
      results();
   end
   initial begin
      rst_n = 1'b0;
      req = '0;
      z = 8'h00;
      kc = 64'h0;
      rst(10);
      for (int i = 0; i < 8; i++) begin
         ka = {ka[55:0], fp(16'hffb0 + 16'(i))};
         kb = {fp(16'hffb0 + 16'(i)), kb[63:8]};
      end
      @(posedge clk) kc <= ka;
      @(negedge clk) check(km, 1'b0);
      @(posedge clk) kc <= kb;
      @(negedge clk) check(km, 1'b1);
      check(key, kb);
      for (int i = 0; i < 200; i++) begin
         a = i < 16 ? cn[i] : 16'($random(seed));
         if (i % 3 == 1) a = a % 16'h0260;
         if (i % 3 == 2) a = {8'h18, 1'b0, a[6:0]};
         go(0, 0, 0, 0, a, 0, 0, 8'($random(seed)), 0);
         check(so.sel, es(a));
         check(so.nv_hit, a >= 16'hffb0 && a <= 16'hffbf);
         check(so.vec_hit, a >= 16'hffce);
         idle;
         if (es(a) == MMVD_SEL_FLASH) check(rd, fp(a) & ~z);
      end
      $display("test regions done");
      for (int i = 0; i < 20; i++) begin
         a = 16'($random(seed)) | 16'h0100;
         a[7:0] = a[7:0] % 8'h60;
         go(0, 1, 0, 0, a, 0, 0, 0, 0);
         check({so.sel, so.addr}, {MMVD_SEL_DP, 8'h00, a[7:0]});
         check(so.dp_slot, a[6:0]);
      end
      $display("test direct done");
      // the bus address is only 0 or 1 and just sets the low-byte bit, so the source picks the vector
      for (int s = 0; s < 14; s++) begin
         go(0, 0, 1, 4'(s), 16'h0000, 0, 0, 0, 0);
         check(fa, vt[s]);
         go(0, 0, 1, 4'(s), 16'h0001, 0, 0, 0, 0);
         check({fa, rd}, {vt[s] + 16'h1, fp(vt[s])});
      end
      $display("test vectors done");
      go(1, 0, 0, 0, 16'h0002, 8'h00, 8'hff, 8'h00, 0);
      acc = 8'h00;
      for (int b = 0; b < 16; b++) begin
         go(1, 0, 0, 0, 16'h0002, 0, 8'h01 << (b % 8), 0, b < 8 ? 2'h1 : 2'h2);
         acc = b < 8 ? acc | (8'h01 << b) : acc & ~(8'h01 << (b - 8));
         go(0, 0, 0, 0, 16'h0002, 0, 8'h01 << (b % 8), 0, 0);
         idle;
         check({rd, bt}, {acc, b < 8});
      end
      $display("test bits done");
      go(1, 0, 0, 0, 16'h0004, 8'hff, 8'hff, 8'hf0, 0);
      go(0, 0, 0, 0, 16'h0004, 0, 0, 0, 0);
      idle;
      check(rd, 8'h0f);
      $display("test unused bits done");
      foreach (hp[i]) begin
         go(0, 0, 0, 0, hp[i], 0, 0, 0, 0);
         check({s_rs, s_lp, s_cg}, hs[i]);
         check({so.sel, so.hp_slot}, {MMVD_SEL_HP, hp[i][6:0]});
      end
      $display("test high page done");
      go(1, 0, 0, 0, 16'hffc4, 8'h55, 8'hff, 0, 0);
      check({so.write, so.sel}, {1'b0, MMVD_SEL_FLASH});
      $display("test flash write done");
      rst(3);
      results();
   end
endmodule
`default_nettype wire

//--- tb/mmvd_decoder_monitor.sv
`default_nettype none
module mmvd_decoder_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire mmvd_pkg::mmvd_req_t req,
   input wire logic [7:0] unused_zero_mask,
   input wire logic [7:0] flash_rdata,
   input wire mmvd_pkg::mmvd_sel_out_t sel_out,
   input wire logic [7:0] rdata,
   input wire logic [15:0] flash_addr,
   input wire logic loading,
   input wire logic [7:0] nv_protection_byte,
   input wire logic [63:0] key_candidate,
   input wire logic [63:0] backdoor_key,
   input wire logic key_match
);
   timeunit 1ns;
   timeprecision 1ps;
   import mmvd_pkg::*;
   logic go;
   // ==========
   // plain accesses; direct and vector fetches remap the address
   assign go = req.valid && !loading && !req.direct && !req.vec_fetch;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_dp_region: assert property (go && req.addr <= 16'h005f |-> sel_out.sel == MMVD_SEL_DP)
      else $error("dp select");
   a_hp_region: assert property (go && req.addr inside {[16'h1800:16'h184f]} |->
      sel_out.sel == MMVD_SEL_HP) else $error("hp select");
   a_nv_block: assert property (go && req.addr inside {[16'hffb0:16'hffbf]} |->
      sel_out.nv_hit && sel_out.sel == MMVD_SEL_FLASH) else $error("nv select");
   a_direct_addr: assert property (req.valid && !loading && req.direct |->
      sel_out.addr == {8'h00, req.addr[7:0]}) else $error("direct addr");
   a_reset_vector: assert property (req.valid && !loading && req.vec_fetch &&
      req.vec_src == MMVD_SRC_RESET |-> flash_addr == {15'h7fff, req.vec_low})
      else $error("reset vector");
   a_nv_load: assert property (rst_n && loading && flash_addr == 16'hffbd |=>
      nv_protection_byte == $past(flash_rdata)) else $error("prot load");
   a_zero_read: assert property (go && !req.write |=>
      (rdata & $past(unused_zero_mask)) == 8'h00) else $error("zero bits");
   a_key_match: assert property (key_match |-> key_candidate == backdoor_key)
      else $error("key match");
   cover property (go && sel_out.sel == MMVD_SEL_DP);
   cover property (req.valid && req.vec_fetch && !loading);
   cover property (key_match);
endmodule
bind mmvd_decoder mmvd_decoder_monitor i_mmvd_decoder_monitor (.clk(clk), .rst_n(rst_n),
   .req(req), .unused_zero_mask(unused_zero_mask), .flash_rdata(flash_rdata),
   .sel_out(sel_out), .rdata(rdata), .flash_addr(flash_addr), .loading(loading),
   .nv_protection_byte(nv_protection_byte), .key_candidate(key_candidate),
   .backdoor_key(backdoor_key), .key_match(key_match));
`default_nettype wire

//--- tb/mmvd_mem_model.sv
`default_nettype none
module mmvd_mem_model (
   input wire logic clk,
   input wire mmvd_pkg::mmvd_sel_out_t sel_out,
   input wire logic [15:0] flash_addr,
   output logic [7:0] slot_rdata,
   output logic [7:0] flash_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import mmvd_pkg::*;
   // ==========
   // slots; high page sits above direct page in one array
   logic [7:0] regs [256];
   logic [7:0] pat = 8'h5a;
   logic hit;
   logic [7:0] ix;
   assign hit = sel_out.sel == MMVD_SEL_HP || sel_out.sel == MMVD_SEL_DP;
   assign ix = sel_out.sel == MMVD_SEL_HP ? {1'b1, sel_out.hp_slot} : {1'b0, sel_out.dp_slot};
   // flash is read only here, a bus write never changes it
   assign flash_rdata = flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h5a;
   // unselected lines toggle so a stale value cannot pass
   assign slot_rdata = hit ? regs[ix] : pat;
   initial foreach (regs[i]) regs[i] = 8'h00;
   always @(posedge clk) begin
      pat <= ~pat;
      if (sel_out.write && hit)
         regs[ix] <= (regs[ix] & ~sel_out.wmask) | (sel_out.wdata & sel_out.wmask);
   end
endmodule
`default_nettype wire

//--- verilog/mmvd_consts.svh
`ifndef MMVD_CONSTS_SVH
`define MMVD_CONSTS_SVH
// ==========================================================
// address regions
`define MMVD_DP_LO 16'h0000
`define MMVD_DP_HI 16'h005f
`define MMVD_HP_LO 16'h1800
`define MMVD_HP_HI 16'h184f
`define MMVD_NV_LO 16'hffb0
`define MMVD_NV_HI 16'hffbf
`define MMVD_RAM_LO 16'h0060
`define MMVD_RAM_HI 16'h025f
`define MMVD_FL_LO 16'he000
// ==========================================================
// nonvolatile block layout (offsets inside the 16 bytes)
`define MMVD_NV_KEY_OFS 4'h0
`define MMVD_NV_PROT_OFS 4'hd
`define MMVD_NV_OPT_OFS 4'hf
// ==========================================================
// high-page fixed slots
`define MMVD_HP_RESET_STATUS 16'h1800
`define MMVD_HP_LOW_POWER 16'h1809
`define MMVD_HP_CLK_GATE1 16'h180e
`define MMVD_HP_CLK_GATE2 16'h180f
// ==========================================================
// vector table (address of high byte)
`define MMVD_VEC_RESET 16'hfffe
`define MMVD_VEC_SWI 16'hfffc
`define MMVD_VEC_IRQ_PIN 16'hfffa
`define MMVD_VEC_LVD 16'hfff8
`define MMVD_VEC_TPM_CH0 16'hfff6
`define MMVD_VEC_TPM_OVF 16'hfff0
`define MMVD_VEC_MTIM 16'hffe6
`define MMVD_VEC_SCI_ERR 16'hffe2
`define MMVD_VEC_SCI_RX 16'hffe0
`define MMVD_VEC_SCI_TX 16'hffde
`define MMVD_VEC_KBI 16'hffda
`define MMVD_VEC_ADC 16'hffd8
`define MMVD_VEC_ACMP 16'hffd6
`define MMVD_VEC_RTC 16'hffce
`define MMVD_VEC_UNUSED_LO 16'hffc0
`define MMVD_VEC_UNUSED_HI 16'hffcd
// ==========================================================
// reset values and timing
`define MMVD_NV_RESET 8'hff
`define MMVD_LOAD_CYCLES 2'h2
`endif

//--- verilog/mmvd_decoder.sv
`default_nettype none
`include "mmvd_consts.svh"
module mmvd_decoder (
   input wire logic clk,
   input wire logic rst_n,
   input wire mmvd_pkg::mmvd_req_t req,
   input wire logic [7:0] unused_zero_mask,
   input wire logic [7:0] slot_rdata,
   input wire logic [7:0] flash_rdata,
   output mmvd_pkg::mmvd_sel_out_t sel_out,
   output logic sel_valid,
   output logic [7:0] rdata,
   output logic bit_test,
   output logic [15:0] flash_addr,
   output logic loading,
   output logic [7:0] nv_protection_byte,
   output logic [7:0] nv_option_byte,
   output logic [63:0] backdoor_key,
   output logic key_match,
   input wire logic [63:0] key_candidate,
   output logic hp_reset_status_sel,
   output logic hp_low_power_sel,
   output logic hp_clk_gate_sel
);
   import mmvd_pkg::*;

   typedef struct packed {
      mmvd_state_t st;
      logic [3:0] key_idx;
      logic [7:0] prot;
      logic [7:0] opt;
      logic [63:0] key;
      logic [7:0] rdata;
      logic btest;
   } mmvd_regs_t;

   mmvd_regs_t r;
   mmvd_regs_t next_r;
   logic [15:0] eff_addr;
   mmvd_sel_t dec_sel;
   logic dec_nv;
   logic dec_vec;
   logic [15:0] load_addr;
   logic key_fetch;
   logic [7:0] read_src;

   // ==========================================================
   // vector address lookup, used for both bytes of a fetch
   function automatic logic [15:0] vec_addr(input mmvd_src_t s, input logic lo);
      logic [15:0] a;
      a = `MMVD_VEC_RESET;
      case (s)
         MMVD_SRC_RESET: a = `MMVD_VEC_RESET;
         MMVD_SRC_SWI: a = `MMVD_VEC_SWI;
         MMVD_SRC_IRQ_PIN: a = `MMVD_VEC_IRQ_PIN;
         MMVD_SRC_LVD: a = `MMVD_VEC_LVD;
         MMVD_SRC_TPM_CH0: a = `MMVD_VEC_TPM_CH0;
         MMVD_SRC_TPM_OVF: a = `MMVD_VEC_TPM_OVF;
         MMVD_SRC_MTIM: a = `MMVD_VEC_MTIM;
         MMVD_SRC_SCI_ERR: a = `MMVD_VEC_SCI_ERR;
         MMVD_SRC_SCI_RX: a = `MMVD_VEC_SCI_RX;
         MMVD_SRC_SCI_TX: a = `MMVD_VEC_SCI_TX;
         MMVD_SRC_KBI: a = `MMVD_VEC_KBI;
         MMVD_SRC_ADC: a = `MMVD_VEC_ADC;
         MMVD_SRC_ACMP: a = `MMVD_VEC_ACMP;
         MMVD_SRC_RTC: a = `MMVD_VEC_RTC;
         default: a = `MMVD_VEC_RESET;
      endcase
      // high byte first, low byte at the next address
      return {a[15:1], lo};
   endfunction

   function automatic logic [15:0] nv_addr(input logic [3:0] ofs);
      return {12'(`MMVD_NV_LO >> 4), ofs};
   endfunction

   // unused-zero bits are dropped on the way in and on the way out
   function automatic logic [7:0] keep_bits(input logic [7:0] d, input logic [7:0] zero_mask);
      return d & ~zero_mask;
   endfunction

   // ==========================================================
   // address formation
   // the key is fetched only on idle cycles, so a request never waits for it
   assign key_fetch = (r.st == MMVD_ST_RUN) && !req.valid && (r.key_idx < 4'h8);

   always_comb begin
      if (r.st != MMVD_ST_RUN || key_fetch) begin
         eff_addr = load_addr;
      end else if (req.vec_fetch) begin
         eff_addr = vec_addr(req.vec_src, req.vec_low);
      end else if (req.direct) begin
         eff_addr = {8'h00, req.addr[7:0]};
      end else begin
         eff_addr = req.addr;
      end
   end

   always_comb begin
      case (r.st)
         MMVD_ST_LOAD_PROT: load_addr = nv_addr(`MMVD_NV_PROT_OFS);
         MMVD_ST_LOAD_OPT: load_addr = nv_addr(`MMVD_NV_OPT_OFS);
         default: load_addr = nv_addr(r.key_idx);
      endcase
   end

   mmvd_region_decode u_dec (
      .addr(eff_addr),
      .sel(dec_sel),
      .nv_hit(dec_nv),
      .vec_hit(dec_vec)
   );

   // ==========================================================
   // outgoing selects
   always_comb begin
      sel_valid = (r.st == MMVD_ST_RUN) && req.valid;
      sel_out.sel = sel_valid ? dec_sel : MMVD_SEL_NONE;
      sel_out.addr = eff_addr;
      sel_out.dp_slot = eff_addr[6:0];
      sel_out.hp_slot = eff_addr[6:0];
      sel_out.nv_hit = sel_valid && dec_nv;
      sel_out.vec_hit = sel_valid && dec_vec;
      // flash is never written by the bus; the write strobe is dropped for the flash select
      sel_out.write = sel_valid && req.write && (dec_sel != MMVD_SEL_FLASH);
      sel_out.wdata = req.wdata;
      sel_out.wmask = keep_bits(8'hff, unused_zero_mask);
      if (req.bit_op != 2'h0 && dec_sel == MMVD_SEL_DP) begin
         // read-modify-write: only the addressed bit is written
         sel_out.wmask = keep_bits(req.bit_mask, unused_zero_mask);
         sel_out.wdata = (req.bit_op == 2'h1) ? req.bit_mask : 8'h00;
      end
      flash_addr = eff_addr;
      loading = (r.st != MMVD_ST_RUN);
   end

   // ==========================================================
   // fixed high-page slots that other blocks watch directly
   always_comb begin
      hp_reset_status_sel = sel_valid && eff_addr == `MMVD_HP_RESET_STATUS;
      hp_low_power_sel = sel_valid && eff_addr == `MMVD_HP_LOW_POWER;
      hp_clk_gate_sel = sel_valid && (eff_addr == `MMVD_HP_CLK_GATE1 ||
                                      eff_addr == `MMVD_HP_CLK_GATE2);
   end

   // ==========================================================
   // working copies and read data straight from flip-flops; key_match is combinational
   always_comb begin
      nv_protection_byte = r.prot;
      nv_option_byte = r.opt;
      backdoor_key = r.key;
      // a half-loaded key must never match, so the byte count gates it too
      key_match = (r.st == MMVD_ST_RUN) && (r.key_idx == 4'h8) &&
                  (key_candidate == r.key);
      rdata = r.rdata;
      bit_test = r.btest;
   end

   // ==========================================================
   // read source: flash for the whole flash region from 16'he000, slots otherwise
   always_comb begin
      if (dec_sel == MMVD_SEL_FLASH) begin
         read_src = flash_rdata;
      end else begin
         read_src = slot_rdata;
      end
   end

   // ==========================================================
   // next state: nv load after reset, then capture per read
   always_comb begin
      next_r = r;
      // read data stands until the next read, so idle cycles keep it
      if (sel_valid && !req.write) begin
         next_r.rdata = keep_bits(read_src, unused_zero_mask);
         next_r.btest = |keep_bits(slot_rdata & req.bit_mask, unused_zero_mask);
      end
      case (r.st)
         MMVD_ST_LOAD_PROT: begin
            next_r.prot = flash_rdata;
            next_r.st = MMVD_ST_LOAD_OPT;
         end
         MMVD_ST_LOAD_OPT: begin
            next_r.opt = flash_rdata;
            next_r.st = MMVD_ST_RUN;
         end
         MMVD_ST_RUN: begin
            // key is loaded once in the background after reset, one byte per idle cycle, eight bytes in all
            if (key_fetch) begin
               next_r.key[8'(r.key_idx) * 8 +: 8] = flash_rdata;
               next_r.key_idx = r.key_idx + 4'h1;
            end
         end
         default: next_r.st = MMVD_ST_LOAD_PROT;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{st: MMVD_ST_LOAD_PROT, key_idx: 4'h0, prot: `MMVD_NV_RESET,
                opt: `MMVD_NV_RESET, key: 64'h0, rdata: 8'h00, btest: 1'b0};
      end else begin
         r <= next_r;
      end
   end

endmodule
`default_nettype wire

//--- verilog/mmvd_pkg.sv
`default_nettype none
package mmvd_pkg;
   typedef enum logic [2:0] {
      MMVD_SEL_NONE,
      MMVD_SEL_DP,
      MMVD_SEL_HP,
      MMVD_SEL_RAM,
      MMVD_SEL_FLASH
   } mmvd_sel_t;

   typedef enum logic [3:0] {
      MMVD_SRC_RESET,
      MMVD_SRC_SWI,
      MMVD_SRC_IRQ_PIN,
      MMVD_SRC_LVD,
      MMVD_SRC_TPM_CH0,
      MMVD_SRC_TPM_OVF,
      MMVD_SRC_MTIM,
      MMVD_SRC_SCI_ERR,
      MMVD_SRC_SCI_RX,
      MMVD_SRC_SCI_TX,
      MMVD_SRC_KBI,
      MMVD_SRC_ADC,
      MMVD_SRC_ACMP,
      MMVD_SRC_RTC
   } mmvd_src_t;

   typedef enum {
      MMVD_ST_LOAD_PROT,
      MMVD_ST_LOAD_OPT,
      MMVD_ST_RUN
   } mmvd_state_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic direct;
      logic vec_fetch;
      mmvd_src_t vec_src;
      logic vec_low;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic [7:0] bit_mask;
      logic [1:0] bit_op;
   } mmvd_req_t;

   typedef struct packed {
      mmvd_sel_t sel;
      logic [15:0] addr;
      logic [6:0] dp_slot;
      logic [6:0] hp_slot;
      logic nv_hit;
      logic vec_hit;
      logic write;
      logic [7:0] wdata;
      logic [7:0] wmask;
   } mmvd_sel_out_t;
endpackage
`default_nettype wire

//--- verilog/mmvd_region_decode.sv
`default_nettype none
`include "mmvd_consts.svh"
module mmvd_region_decode (
   input wire logic [15:0] addr,
   output mmvd_pkg::mmvd_sel_t sel,
   output logic nv_hit,
   output logic vec_hit
);
   import mmvd_pkg::*;
   // ==========================================================
   // region compare
   always_comb begin
      nv_hit = (addr >= `MMVD_NV_LO) && (addr <= `MMVD_NV_HI);
      vec_hit = (addr >= `MMVD_VEC_RTC);
      if (addr <= `MMVD_DP_HI) begin
         sel = MMVD_SEL_DP;
      end else if (addr >= `MMVD_HP_LO && addr <= `MMVD_HP_HI) begin
         sel = MMVD_SEL_HP;
      end else if (addr >= `MMVD_RAM_LO && addr <= `MMVD_RAM_HI) begin
         sel = MMVD_SEL_RAM;
      end else if (addr >= `MMVD_FL_LO) begin
         // nv block and vector space are flash, unused vectors included
         sel = MMVD_SEL_FLASH;
      end else begin
         sel = MMVD_SEL_NONE;
      end
   end
endmodule
`default_nettype wire
